// [hw/acm_pkg.sv]
// Package: register map, field positions, reset values and timing constants
// Functional notes
// [R1] Host never writes reserved ranges 00-1F and 34-3F.
// [R2] Each byte register is selected by a 7-bit register address.
// [R3] Host should not alter calibration values loaded at boot.
// [R4] At power-up trimming values are copied from nonvolatile storage.
// [R5] Rate select bit: 0 gives 100 Hz samples, 1 gives 400 Hz.
// [R6] Active mode bit: 0 keeps power-down, 1 measures.
// [R7] Either self-test bit at one shifts the outputs; zero is normal.
// [R8] Axis enable bits, reset to 1, gate that axis's data-ready.
// [R9] Three-wire bit: 0 data out on serial out pin, 1 on shared pin.
// [R10] Reboot bit reloads trimming, then clears itself when done.
// [R11] Host keeps unused control_two and pin_event_control bits at zero.
// [R12] Host keeps pin_event_control bit 6 zero for push-pull pin.
// [R13] Polarity bit: 0 pin active high, 1 active low.
// [R14] Source 000 ground, 001 motion event, 100 data ready; others unused.
// [R15] Per-axis new-sample flags, and combined flag for full three-axis set; code sets it once all enabled axes have new data.
// [R16] Per-axis and combined overrun when unread sample is overwritten.
// [R17] X and Y outputs are 8-bit two's complement read-only registers.
// [R18] Z output is an 8-bit two's complement read-only register.
// [R19] Reading motion_event_source clears it and its interrupt.
// [R20] Reading an axis clears its flag; combined clears after enabled reads.
// [R21] Writes to read-only or unused addresses ignored; unused reads zero.
// [R22] Power-down stops output updates and new-sample flag setting.
package acm_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int TRIM_W = 8;
  localparam int AXES = 3;

  localparam logic [ADDR_W-1:0] ADR_CTRL1 = 7'h20;
  localparam logic [ADDR_W-1:0] ADR_CTRL2 = 7'h21;
  localparam logic [ADDR_W-1:0] ADR_PINCTL = 7'h22;
  localparam logic [ADDR_W-1:0] ADR_FLAGS = 7'h27;
  localparam logic [ADDR_W-1:0] ADR_X = 7'h29;
  localparam logic [ADDR_W-1:0] ADR_Y = 7'h2B;
  localparam logic [ADDR_W-1:0] ADR_Z = 7'h2D;
  localparam logic [ADDR_W-1:0] ADR_EV_CFG = 7'h30;
  localparam logic [ADDR_W-1:0] ADR_EV_SRC = 7'h31;
  localparam logic [ADDR_W-1:0] ADR_EV_THS = 7'h32;
  localparam logic [ADDR_W-1:0] ADR_EV_DUR = 7'h33;

  localparam logic [DATA_W-1:0] RST_CTRL1 = 8'h07;
  localparam logic [DATA_W-1:0] RST_CTRL2 = 8'h00;
  localparam logic [DATA_W-1:0] RST_PINCTL = 8'h00;
  localparam logic [DATA_W-1:0] RST_EV_CFG = 8'h00;
  localparam logic [DATA_W-1:0] RST_EV_THS = 8'h02;
  localparam logic [DATA_W-1:0] RST_EV_DUR = 8'h00;
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;

  // control_one fields
  localparam int B_RATE = 7;
  localparam int B_ACTIVE = 6;
  localparam int B_FS = 5;
  localparam int B_STP = 4;
  localparam int B_STM = 3;
  // control_two fields
  localparam int B_3WIRE = 7;
  localparam int B_REBOOT = 6;
  localparam logic [DATA_W-1:0] CTRL2_MASK = 8'hC0;
  // pin_event_control fields
  localparam int B_POL = 7;
  localparam logic [DATA_W-1:0] PINCTL_MASK = 8'h87;
  localparam logic [2:0] SRC_GND = 3'h0;
  localparam logic [2:0] SRC_EVENT = 3'h1;
  localparam logic [2:0] SRC_DRDY = 3'h4;
  // motion_event_config / source fields
  localparam int B_LATCH = 6;
  localparam int B_ACTIVE_EV = 6;

  // Sample periods at 200 MHz clock
  localparam real CLK_NS = 5.0;
  localparam real SLOW_HZ = 100.0;
  localparam real FAST_HZ = 400.0;
  localparam int SLOW_CYC = int'(1.0e9 / (SLOW_HZ * CLK_NS));
  localparam int FAST_CYC = int'(1.0e9 / (FAST_HZ * CLK_NS));
  localparam logic [DATA_W-1:0] SELFTEST_OFS = 8'h10;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } acm_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] x;
    logic [DATA_W-1:0] y;
    logic [DATA_W-1:0] z;
  } acm_axes_t;
endpackage

// [hw/acm_rate_tick.sv]
// Sample strobe generator for the two output data rates
`timescale 1ns/1ps
module acm_rate_tick #(
  parameter int SLOW_CYC = acm_pkg::SLOW_CYC,
  parameter int FAST_CYC = acm_pkg::FAST_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic i_fast,
  output logic o_tick
);
  if (FAST_CYC < 2 || SLOW_CYC < FAST_CYC)
  begin : g_bad_period
    $error("acm_rate_tick: bad period");
  end
  logic [31:0] cnt_r;
  wire [31:0] limit = i_fast ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);
  wire wrap = cnt_r >= limit;
  assign o_tick = i_run && wrap;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt_r <= 32'h0;
    else if (i_ce)
      cnt_r <= (!i_run || wrap) ? 32'h0 : cnt_r + 32'h1;
  end
endmodule // acm_rate_tick

// [hw/acm_regs.sv]
// Register bank of the three-axis accelerometer behind the serial slave
`timescale 1ns/1ps
module acm_regs #(
  parameter int TRIM_WORDS = 4,
  parameter int SLOW_CYC = acm_pkg::SLOW_CYC,
  parameter int FAST_CYC = acm_pkg::FAST_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire acm_pkg::acm_req_t i_req,
  output logic [acm_pkg::DATA_W-1:0] o_rdata,
  input wire acm_pkg::acm_axes_t i_sample,
  input wire logic i_event,
  input wire logic [5:0] i_event_axes,
  input wire logic [acm_pkg::TRIM_W-1:0] i_nv_data,
  output logic [$clog2(TRIM_WORDS)-1:0] o_nv_addr,
  output logic [TRIM_WORDS*acm_pkg::TRIM_W-1:0] o_trim,
  output logic o_boot_busy,
  output logic o_active,
  output logic o_fast,
  output logic o_full_scale,
  output logic o_three_wire,
  output logic o_int_pin,
  output logic [acm_pkg::DATA_W-1:0] o_ev_cfg,
  output logic [acm_pkg::DATA_W-1:0] o_ev_ths,
  output logic [acm_pkg::DATA_W-1:0] o_ev_dur
);
  localparam int DW = acm_pkg::DATA_W;
  if (acm_pkg::ADDR_W != 7 || DW != 8)
  begin : g_bad_map
    $error("acm_regs: map needs 7-bit address and byte data");
  end

  logic [DW-1:0] ctrl1_r, ctrl2_r, pinctl_r;
  logic [DW-1:0] evcfg_r, evsrc_r, evths_r, evdur_r;
  logic [acm_pkg::AXES-1:0] new_r, ovr_r, rd_seen_r;
  logic all_new_r, all_ovr_r;
  logic [DW-1:0] axis_r [acm_pkg::AXES];
  logic [DW-1:0] rdata_r;
  logic tick;
  logic boot_busy, boot_busy_q;

  // Address decode on the 7-bit register index
  wire wr = i_req.wr; // R2
  wire rd = i_req.rd; // R2
  wire [6:0] a = i_req.addr;
  wire hit_c1 = a == acm_pkg::ADR_CTRL1;
  wire hit_c2 = a == acm_pkg::ADR_CTRL2;
  wire hit_pc = a == acm_pkg::ADR_PINCTL;
  wire hit_ec = a == acm_pkg::ADR_EV_CFG;
  wire hit_es = a == acm_pkg::ADR_EV_SRC;
  wire hit_et = a == acm_pkg::ADR_EV_THS;
  wire hit_ed = a == acm_pkg::ADR_EV_DUR;
  wire [acm_pkg::AXES-1:0] hit_ax = {a == acm_pkg::ADR_Z,
    a == acm_pkg::ADR_Y, a == acm_pkg::ADR_X};
  wire [acm_pkg::AXES-1:0] rd_ax = hit_ax & {acm_pkg::AXES{rd}}; // R20
  wire rd_src = rd && hit_es; // R19
  wire active = ctrl1_r[acm_pkg::B_ACTIVE]; // R6
  wire [acm_pkg::AXES-1:0] ax_en = ctrl1_r[acm_pkg::AXES-1:0]; // R8
  wire selftest = ctrl1_r[acm_pkg::B_STP] | ctrl1_r[acm_pkg::B_STM];
  wire st_neg = ctrl1_r[acm_pkg::B_STM];
  wire [acm_pkg::AXES-1:0] upd = {acm_pkg::AXES{tick}} & ax_en; // R8 R22

  acm_rate_tick #(
    .SLOW_CYC(SLOW_CYC),
    .FAST_CYC(FAST_CYC)
  ) u_tick (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_run(active), // R22
    .i_fast(ctrl1_r[acm_pkg::B_RATE]), // R5
    .o_tick(tick)
  );

  // Reboot bit clears on the falling edge of the loader busy flag;
  // start is held off in that cycle, or the reload would run twice
  wire boot_done = boot_busy_q && !boot_busy;
  acm_trim_load #(
    .WORDS(TRIM_WORDS)
  ) u_trim (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_start(ctrl2_r[acm_pkg::B_REBOOT] && !boot_done), // R10
    .i_nv_data(i_nv_data),
    .o_nv_addr(o_nv_addr),
    .o_busy(boot_busy),
    .o_trim(o_trim)
  );

  wire [DW-1:0] ctrl2_wmask = acm_pkg::CTRL2_MASK;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl1_r <= acm_pkg::RST_CTRL1;
      ctrl2_r <= acm_pkg::RST_CTRL2;
      pinctl_r <= acm_pkg::RST_PINCTL;
      evcfg_r <= acm_pkg::RST_EV_CFG;
      evths_r <= acm_pkg::RST_EV_THS;
      evdur_r <= acm_pkg::RST_EV_DUR;
      boot_busy_q <= 1'b1;
    end
    else if (i_ce)
    begin
      boot_busy_q <= boot_busy;
      // Only mapped read/write registers take writes
      if (wr && hit_c1)
        ctrl1_r <= i_req.wdata; // R5 R6 R7 R8 R21
      if (wr && hit_pc)
        pinctl_r <= i_req.wdata & acm_pkg::PINCTL_MASK; // R13 R14
      if (wr && hit_ec)
        evcfg_r <= i_req.wdata;
      if (wr && hit_et)
        evths_r <= i_req.wdata;
      if (wr && hit_ed)
        evdur_r <= i_req.wdata;
      if (wr && hit_c2)
        ctrl2_r <= i_req.wdata & ctrl2_wmask; // R9 R10
      else if (boot_done)
        ctrl2_r[acm_pkg::B_REBOOT] <= 1'b0; // R10
    end
  end

  // Per-axis sample store and status flags
  genvar g;
  generate
    for (g = 0; g < acm_pkg::AXES; g++)
    begin : g_axis
      logic [DW-1:0] raw;
      logic [DW-1:0] shifted;
      if (g == 0)
        assign raw = i_sample.x;
      else if (g == 1)
        assign raw = i_sample.y;
      else
        assign raw = i_sample.z;
      // Self-test pushes a fixed offset through the chain, sign by bit
      assign shifted = !selftest ? raw : st_neg ?
        raw - acm_pkg::SELFTEST_OFS : raw + acm_pkg::SELFTEST_OFS; // R7
      always_ff @(posedge i_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          axis_r[g] <= acm_pkg::RST_ZERO;
          new_r[g] <= 1'b0;
          ovr_r[g] <= 1'b0;
        end
        else if (i_ce)
        begin
          if (upd[g])
            axis_r[g] <= shifted; // R17 R18 R22
          // A new sample wins over a read in the same cycle
          new_r[g] <= upd[g] | (new_r[g] & !rd_ax[g]); // R15 R20
          ovr_r[g] <= (upd[g] & new_r[g] & !rd_ax[g]) |
            (ovr_r[g] & !rd_ax[g]); // R16
        end
      end
    end
  endgenerate

  // Combined flags follow the enabled axes as a set
  wire set_done = |upd && ((new_r | upd) & ax_en) == ax_en; // R15
  wire all_read = ((rd_seen_r | rd_ax) & ax_en) == ax_en; // R20
  wire set_ovr = |(upd & new_r & ~rd_ax); // R16
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      all_new_r <= 1'b0;
      all_ovr_r <= 1'b0;
      rd_seen_r <= '0;
    end
    else if (i_ce)
    begin
      if (set_done)
      begin
        all_new_r <= 1'b1; // R15
        rd_seen_r <= '0;
      end
      else if (all_new_r && all_read)
      begin
        all_new_r <= 1'b0; // R20
        rd_seen_r <= '0;
      end
      else
        rd_seen_r <= rd_seen_r | rd_ax;
      if (set_ovr)
        all_ovr_r <= 1'b1; // R16
      else if (all_read && all_new_r)
        all_ovr_r <= 1'b0;
    end
  end

  // Motion event source: latched or live, cleared by read
  wire latch_ev = evcfg_r[acm_pkg::B_LATCH];
  wire [DW-1:0] ev_now = {1'b0, i_event, i_event_axes};
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      evsrc_r <= acm_pkg::RST_ZERO;
    else if (i_ce)
    begin
      // A fresh event in the read cycle is kept, not lost
      if (!latch_ev)
        evsrc_r <= ev_now;
      else
        evsrc_r <= (rd_src ? acm_pkg::RST_ZERO : evsrc_r) | ev_now; // R19
    end
  end

  // Read mux: unused and reserved addresses read zero
  wire [DW-1:0] flags = {all_ovr_r, ovr_r[2], ovr_r[1], ovr_r[0],
    all_new_r, new_r[2], new_r[1], new_r[0]};
  wire [DW-1:0] rd_mux =
    hit_c1 ? ctrl1_r :
    hit_c2 ? ctrl2_r :
    hit_pc ? pinctl_r :
    (a == acm_pkg::ADR_FLAGS) ? flags :
    hit_ax[0] ? axis_r[0] :
    hit_ax[1] ? axis_r[1] :
    hit_ax[2] ? axis_r[2] :
    hit_ec ? evcfg_r :
    hit_es ? evsrc_r :
    hit_et ? evths_r :
    hit_ed ? evdur_r : acm_pkg::RST_ZERO; // R21
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_r <= acm_pkg::RST_ZERO;
    else if (i_ce && rd)
      rdata_r <= rd_mux;
  end
  assign o_rdata = rdata_r;

  // Interrupt pin source and polarity
  wire [2:0] src_sel = pinctl_r[2:0];
  wire ev_active = evsrc_r[acm_pkg::B_ACTIVE_EV];
  wire pin_level = (src_sel == acm_pkg::SRC_EVENT) ? ev_active :
    (src_sel == acm_pkg::SRC_DRDY) ? all_new_r : 1'b0; // R14
  logic int_r;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      int_r <= 1'b0;
    else if (i_ce)
      int_r <= pin_level ^ pinctl_r[acm_pkg::B_POL]; // R13
  end
  assign o_int_pin = int_r;

  assign o_boot_busy = boot_busy;
  assign o_active = active;
  assign o_fast = ctrl1_r[acm_pkg::B_RATE];
  assign o_full_scale = ctrl1_r[acm_pkg::B_FS];
  assign o_three_wire = ctrl2_r[acm_pkg::B_3WIRE]; // R9
  assign o_ev_cfg = evcfg_r;
  assign o_ev_ths = evths_r;
  assign o_ev_dur = evdur_r;

  chk_pd_no_update: assert property ( // R22
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !active) |=> $stable(axis_r[0]) && $stable(axis_r[1]))
    else $error("axis changed in power-down");
  chk_read_clears_x: assert property ( // R20
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && rd_ax[0] && !upd[0]) |=> !new_r[0])
    else $error("x flag not cleared by read");
  chk_tick_sets_new: assert property ( // R15
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && upd[1]) |=> new_r[1])
    else $error("y flag not set on sample");
  chk_overrun_set: assert property ( // R16
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && upd[2] && new_r[2] && !rd_ax[2]) |=> ovr_r[2] && all_ovr_r)
    else $error("overrun missed");
  chk_axis_gate: assert property ( // R8
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !ax_en[1] && !new_r[1]) |=> !new_r[1])
    else $error("disabled axis flagged");
  chk_src_read_clr: assert property ( // R19
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && latch_ev && rd_src && !i_event && i_event_axes == 6'h00)
    |=> evsrc_r == acm_pkg::RST_ZERO)
    else $error("source not cleared by read");
  chk_pin_ground: assert property ( // R13 R14
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && src_sel == acm_pkg::SRC_GND) |=>
    int_r == $past(pinctl_r[acm_pkg::B_POL]))
    else $error("ground source not idle level");
  chk_reboot_clears: assert property ( // R10
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && boot_done && !(wr && hit_c2)) |=> !ctrl2_r[acm_pkg::B_REBOOT])
    else $error("reboot bit stuck");
  chk_ro_write: assert property ( // R21
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && wr && a == acm_pkg::ADR_FLAGS) |=> $stable(ctrl1_r))
    else $error("write to status leaked");
  chk_reboot_once: assert property ( // R10
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && boot_done) |=> !boot_busy)
    else $error("reload restarted after reboot");
  chk_drdy_pin: assert property ( // R13 R14
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && src_sel == acm_pkg::SRC_DRDY) |=>
    int_r == ($past(all_new_r) ^ $past(pinctl_r[acm_pkg::B_POL])))
    else $error("data-ready pin level wrong");
  chk_event_pin: assert property ( // R14 R19
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && src_sel == acm_pkg::SRC_EVENT) |=>
    int_r == ($past(ev_active) ^ $past(pinctl_r[acm_pkg::B_POL])))
    else $error("event pin level wrong");
  chk_ctrl1_read: assert property ( // R2
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && rd && hit_c1) |=> rdata_r == $past(ctrl1_r))
    else $error("control_one read data wrong");
  chk_selftest_plus: assert property ( // R7
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && upd[0] && selftest && !st_neg) |=>
    axis_r[0] == DW'($past(i_sample.x) + acm_pkg::SELFTEST_OFS))
    else $error("self-test offset missing");
  chk_all_read_clr: assert property ( // R20
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && all_new_r && all_read && !set_done) |=> !all_new_r)
    else $error("combined flag not cleared by reads");
  cov_ev_clr: cover property (@(posedge i_clk) rd_src && ev_active);
  cov_drdy: cover property (@(posedge i_clk) all_new_r ##1 !all_new_r);
  cov_ovr: cover property (@(posedge i_clk) all_ovr_r);
  cov_reboot: cover property (@(posedge i_clk) boot_done);
  cov_int: cover property (@(posedge i_clk) $rose(int_r));
endmodule // acm_regs

// [hw/acm_trim_load.sv]
// Copies factory trimming words from nonvolatile storage into trim registers
`timescale 1ns/1ps
module acm_trim_load #(
  parameter int WORDS = 4
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [acm_pkg::TRIM_W-1:0] i_nv_data,
  output logic [$clog2(WORDS)-1:0] o_nv_addr,
  output logic o_busy,
  output logic [WORDS*acm_pkg::TRIM_W-1:0] o_trim
);
  if (WORDS < 2)
  begin : g_bad_words
    $error("acm_trim_load: WORDS must be at least 2");
  end
  localparam int AW = $clog2(WORDS);
  logic busy_r;
  logic [AW-1:0] idx_r;
  logic [acm_pkg::TRIM_W-1:0] trim_r [WORDS];
  // Power-up counts as a start: busy comes out of reset set
  wire last = idx_r == AW'(WORDS - 1);
  assign o_busy = busy_r;
  assign o_nv_addr = idx_r;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      busy_r <= 1'b1; // R4
      idx_r <= '0;
    end
    else if (i_ce)
    begin
      if (busy_r)
      begin
        idx_r <= last ? '0 : idx_r + 1'b1;
        busy_r <= !last;
      end
      else if (i_start)
        busy_r <= 1'b1; // R10
    end
  end
  genvar g;
  generate
    for (g = 0; g < WORDS; g++)
    begin : g_trim
      always_ff @(posedge i_clk or negedge i_nrst)
      begin
        if (!i_nrst)
          trim_r[g] <= '0;
        else if (i_ce && busy_r && idx_r == AW'(g))
          trim_r[g] <= i_nv_data; // R4
      end
      assign o_trim[g*acm_pkg::TRIM_W +: acm_pkg::TRIM_W] = trim_r[g];
    end
  endgenerate
endmodule // acm_trim_load

// [tb/accel_control_map_test.sv]
// Self-checking bench for the accelerometer register bank
`timescale 1ns/1ps
module accel_control_map_test;
  localparam int SLOW = 40;
  localparam int FAST = 10;
  localparam logic [6:0] RA [8] = '{7'h20, 7'h21, 7'h22, 7'h27,
    7'h30, 7'h31, 7'h32, 7'h33};
  localparam logic [7:0] RV [8] = '{8'h07, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h02, 8'h00};
  localparam logic [6:0] MA [3] = '{7'h30, 7'h32, 7'h33};
  localparam logic [7:0] MV [3] = '{8'h7F, 8'h15, 8'h33};
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic ce = 1'b1;
  acm_pkg::acm_req_t req = '0;
  acm_pkg::acm_axes_t smp = '0;
  logic ev = 1'b0;
  logic [5:0] ev_axes = 6'h00;
  logic [7:0] nv_data;
  logic [1:0] nv_addr;
  logic [31:0] trim;
  logic busy, act, fast, fs, tw, int_pin;
  logic [7:0] rdata, ev_cfg, ev_ths, ev_dur, d;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0;

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;

  acm_regs #(.TRIM_WORDS(4), .SLOW_CYC(SLOW), .FAST_CYC(FAST)) DUT (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_req(req),
    .o_rdata(rdata), .i_sample(smp), .i_event(ev),
    .i_event_axes(ev_axes), .i_nv_data(nv_data), .o_nv_addr(nv_addr),
    .o_trim(trim), .o_boot_busy(busy), .o_active(act), .o_fast(fast),
    .o_full_scale(fs), .o_three_wire(tw), .o_int_pin(int_pin),
    .o_ev_cfg(ev_cfg), .o_ev_ths(ev_ths), .o_ev_dur(ev_dur)
  );
  acm_nv_model #(.WORDS(4)) nv (.i_addr(nv_addr), .o_data(nv_data));

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge i_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge i_clk);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge i_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] m,
    input logic [7:0] e);
    rd(a, d);
    chk(d & m, e);
  endtask

  task automatic wait_x();
    int n;
    n = 0;
    d = 8'h00;
    while (d[0] !== 1'b1 && n < 200)
    begin
      rd(acm_pkg::ADR_FLAGS, d);
      n++;
    end
    chk(d[0], 1'b1);
  endtask

  // Both detections follow a cleared flag, so they share the tick phase
  task automatic per(input int p);
    rd(acm_pkg::ADR_X, d);
    wait_x();
    t0 = cyc;
    rd(acm_pkg::ADR_X, d);
    wait_x();
    chk(cyc - t0, p);
  endtask

  task automatic st_x(input logic [7:0] cfg, input logic [7:0] e);
    wr(acm_pkg::ADR_CTRL1, cfg);
    rd(acm_pkg::ADR_X, d);
    wait_x();
    rchk(acm_pkg::ADR_X, 8'hFF, e);
  endtask

  task automatic pin(input logic e);
    repeat (2) @(posedge i_clk);
    #1;
    chk(int_pin, e);
  endtask

  initial
  begin
    #200000;
    num_errors++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge i_clk);
    chk(busy, 1'b1);
    chk(int_pin, 1'b0);
    i_nrst <= 1'b1;
    repeat (20) if (busy === 1'b1) @(posedge i_clk);
    #1;
    chk(busy, 1'b0);
    chk(trim, 32'hA3A2A1A0);
    for (int i = 0; i < 8; i++)
      rchk(RA[i], 8'hFF, RV[i]);
    @(posedge i_clk);
    smp <= '{x: 8'h12, y: 8'hF0, z: 8'h7F};
    repeat (100) @(posedge i_clk);
    rchk(acm_pkg::ADR_FLAGS, 8'hFF, 8'h00);
    wr(acm_pkg::ADR_CTRL1, 8'hC7);
    chk({act, fast, fs}, 3'b110);
    per(FAST);
    wr(acm_pkg::ADR_CTRL1, 8'h47);
    chk(fast, 1'b0);
    per(SLOW);
    rchk(acm_pkg::ADR_Y, 8'hFF, 8'hF0);
    rchk(acm_pkg::ADR_Z, 8'hFF, 8'h7F);
    wr(acm_pkg::ADR_PINCTL, 8'h04);
    repeat (100) @(posedge i_clk);
    rchk(acm_pkg::ADR_FLAGS, 8'hFF, 8'hFF);
    pin(1'b1);
    wr(acm_pkg::ADR_PINCTL, 8'h84);
    pin(1'b0);
    // Power-down first so no tick races the clearing reads
    wr(acm_pkg::ADR_CTRL1, 8'h07);
    rchk(acm_pkg::ADR_X, 8'hFF, 8'h12);
    rchk(acm_pkg::ADR_FLAGS, 8'h0F, 8'h0E);
    rd(acm_pkg::ADR_Y, d);
    rd(acm_pkg::ADR_Z, d);
    rchk(acm_pkg::ADR_FLAGS, 8'h8F, 8'h00);
    wr(acm_pkg::ADR_PINCTL, 8'h04);
    pin(1'b0);
    @(posedge i_clk);
    smp.x <= 8'h55;
    repeat (100) @(posedge i_clk);
    rchk(acm_pkg::ADR_X, 8'hFF, 8'h12);
    rchk(acm_pkg::ADR_FLAGS, 8'h0F, 8'h00);
    st_x(8'h57, 8'h65);
    st_x(8'h4F, 8'h45);
    wr(acm_pkg::ADR_CTRL1, 8'h41);
    rd(acm_pkg::ADR_X, d);
    rd(acm_pkg::ADR_Y, d);
    rd(acm_pkg::ADR_Z, d);
    wait_x();
    chk(d & 8'h0F, 8'h09);
    wr(acm_pkg::ADR_CTRL1, 8'h07);
    wr(acm_pkg::ADR_CTRL2, 8'h80);
    chk(tw, 1'b1);
    rchk(acm_pkg::ADR_CTRL2, 8'hFF, 8'h80);
    wr(acm_pkg::ADR_CTRL2, 8'h40);
    @(posedge i_clk);
    #1;
    chk(busy, 1'b1);
    repeat (20) if (busy === 1'b1) @(posedge i_clk);
    #1;
    chk({busy, tw}, 2'b00);
    chk(trim, 32'hA3A2A1A0);
    rchk(acm_pkg::ADR_CTRL2, 8'hFF, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(MA[i], MV[i]);
      rchk(MA[i], 8'hFF, MV[i]);
    end
    chk({ev_cfg, ev_ths, ev_dur}, 24'h7F1533);
    wr(acm_pkg::ADR_PINCTL, 8'h01);
    @(posedge i_clk);
    ev <= 1'b1;
    ev_axes <= 6'h21;
    repeat (4) @(posedge i_clk);
    ev <= 1'b0;
    ev_axes <= 6'h00;
    pin(1'b1);
    rchk(acm_pkg::ADR_EV_SRC, 8'hFF, 8'h61);
    pin(1'b0);
    rchk(acm_pkg::ADR_EV_SRC, 8'hFF, 8'h00);
    wr(acm_pkg::ADR_X, 8'hFF);
    wr(acm_pkg::ADR_EV_SRC, 8'hFF);
    wr(7'h28, 8'hAA);
    rchk(acm_pkg::ADR_X, 8'hFF, 8'h55);
    rchk(acm_pkg::ADR_EV_SRC, 8'hFF, 8'h00);
    rchk(7'h28, 8'hFF, 8'h00);
    rchk(7'h2A, 8'hFF, 8'h00);
    // A write while the clock enable is low must not land
    @(posedge i_clk);
    ce <= 1'b0;
    wr(acm_pkg::ADR_CTRL1, 8'h27);
    @(posedge i_clk);
    ce <= 1'b1;
    rchk(acm_pkg::ADR_CTRL1, 8'hFF, 8'h07);
    wr(acm_pkg::ADR_CTRL1, 8'h27);
    chk({act, fs}, 2'b01);
    conclude();
  end
endmodule // accel_control_map_test

// [tb/acm_nv_model.sv]
// Nonvolatile trim store model answering the loader's word index
`timescale 1ns/1ps
module acm_nv_model #(
  parameter int WORDS = 4
) (
  input wire logic [$clog2(WORDS)-1:0] i_addr,
  output logic [acm_pkg::TRIM_W-1:0] o_data
);
  // Arbitrary contents; distinct words expose swapped or skipped indices
  assign o_data = 8'hA0 + 8'(i_addr);
endmodule // acm_nv_model
